// *** rtl/fast_detect_pkg.sv ***
package fast_detect_pkg;
   // Printed offsets are not all multiples of four: each is a word index, byte address = 4 * index
   localparam logic [9:0] IDX_DETECT_CONTROL = 10'h245;
   localparam logic [9:0] IDX_UPPER_LOW = 10'h247;
   localparam logic [9:0] IDX_UPPER_HIGH = 10'h248;
   localparam logic [9:0] IDX_LOWER_LOW = 10'h249;
   localparam logic [9:0] IDX_LOWER_HIGH = 10'h24A;
   localparam logic [9:0] IDX_DWELL_LOW = 10'h24B;
   localparam logic [9:0] IDX_DWELL_HIGH = 10'h24C;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h250;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h251;
   localparam int BIT_ENABLE = 0;
   localparam int BIT_FORCE_VALUE = 2;
   localparam int BIT_FORCE = 3;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'h0D;
   localparam logic [7:0] HIGH_WRITE_MASK = 8'h1F;
   localparam int BIT_EV_ASSERT = 0;
   localparam int BIT_EV_RELEASE = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [12:0] RESET_THRESHOLD = 13'h0000;
   localparam logic [15:0] RESET_COUNT = 16'h0000;

   typedef enum logic [1:0] {
      IDLE = 2'b00,
      ABOVE = 2'b01,
      DWELL = 2'b11
   } detect_state_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [31:0] writedata;
   } bus_request_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } bus_answer_type;

   typedef struct packed {
      logic [7:0] control;
      logic [12:0] upper;
      logic [12:0] lower;
      logic [15:0] dwell;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      detect_state_type state;
      logic [15:0] count;
      logic flag;
      logic pin;
      logic answered;
      logic [31:0] readdata;
   } detect_regs_type;
endpackage

// *** rtl/adc_fast_threshold_detect.sv ***
// Behaviour
// - Detection stays inactive while enable is 0, and so does the pin unless force is 1; detection runs when 1.
// - Force bit 0: pin follows detection; force bit 1: pin takes forced level.
// - With override active the pin equals the forced-value bit exactly.
// - 13-bit upper threshold, low byte plus high five bits, compared with magnitude.
// - 13-bit lower threshold, low byte plus high five bits, compared with magnitude.
// - Dwell counter loads target; pin clears after magnitude stays below lower for target plus one enabled cycles, two at least.
// - Dwell target bits 7:0 in low register, bits 15:8 in high register.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_fast_threshold_detect (
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire fast_detect_pkg::bus_request_type bus_req,
   output fast_detect_pkg::bus_answer_type bus_ans,
   input wire logic [12:0] sample_magnitude,
   output logic over_range_flag_pin,
   output logic irq
);
   import fast_detect_pkg::*;

   detect_regs_type r_reg;
   detect_regs_type r_next;
   logic [9:0] index;
   logic access;
   logic hit_write;
   logic above;
   logic below;
   logic [1:0] events;

   assign index = bus_req.address[11:2];
   assign access = (bus_req.read | bus_req.write) & ~r_reg.answered;
   // Writes land on the completion edge, the one where the master sees waitrequest low
   assign hit_write = bus_req.write & r_reg.answered;
   assign above = sample_magnitude > r_reg.upper;
   assign below = sample_magnitude < r_reg.lower;

   always_comb begin
      r_next = r_reg;
      events = 2'b00;
      // One wait cycle per access so readdata comes from a flop
      r_next.answered = access;
      if (access && bus_req.read) begin
         r_next.readdata = 32'h0000_0000;
         case (index)
            IDX_DETECT_CONTROL: r_next.readdata[7:0] = r_reg.control;
            IDX_UPPER_LOW: r_next.readdata[7:0] = r_reg.upper[7:0];
            IDX_UPPER_HIGH: r_next.readdata[4:0] = r_reg.upper[12:8];
            IDX_LOWER_LOW: r_next.readdata[7:0] = r_reg.lower[7:0];
            IDX_LOWER_HIGH: r_next.readdata[4:0] = r_reg.lower[12:8];
            IDX_DWELL_LOW: r_next.readdata[7:0] = r_reg.dwell[7:0];
            IDX_DWELL_HIGH: r_next.readdata[7:0] = r_reg.dwell[15:8];
            IDX_IRQ_STATUS: r_next.readdata[1:0] = r_reg.irq_status;
            IDX_IRQ_MASK: r_next.readdata[1:0] = r_reg.irq_mask;
            default: r_next.readdata = 32'h0000_0000;
         endcase
      end
      if (hit_write) begin
         case (index)
            IDX_DETECT_CONTROL: r_next.control = bus_req.writedata[7:0] & CONTROL_WRITE_MASK;
            IDX_UPPER_LOW: r_next.upper[7:0] = bus_req.writedata[7:0];
            IDX_UPPER_HIGH: r_next.upper[12:8] = bus_req.writedata[4:0];
            IDX_LOWER_LOW: r_next.lower[7:0] = bus_req.writedata[7:0];
            IDX_LOWER_HIGH: r_next.lower[12:8] = bus_req.writedata[4:0];
            IDX_DWELL_LOW: r_next.dwell[7:0] = bus_req.writedata[7:0];
            IDX_DWELL_HIGH: r_next.dwell[15:8] = bus_req.writedata[7:0];
            IDX_IRQ_MASK: r_next.irq_mask = bus_req.writedata[1:0];
            default: ;
         endcase
      end
      // Detection state machine
      if (!r_reg.control[BIT_ENABLE]) begin
         r_next.state = IDLE;
         r_next.flag = 1'b0;
         r_next.count = RESET_COUNT;
      end else begin
         case (r_reg.state)
            IDLE: begin
               if (above) begin
                  r_next.state = ABOVE;
                  r_next.flag = 1'b1;
                  events[BIT_EV_ASSERT] = 1'b1;
               end
            end
            ABOVE: begin
               if (below && !above) begin
                  r_next.state = DWELL;
                  r_next.count = r_reg.dwell;
               end
            end
            DWELL: begin
               if (above || !below) begin
                  r_next.state = ABOVE;
               end else if (r_reg.count <= 16'h0001) begin
                  r_next.state = IDLE;
                  r_next.flag = 1'b0;
                  events[BIT_EV_RELEASE] = 1'b1;
               end else begin
                  r_next.count = r_reg.count - 16'h0001;
               end
            end
            default: begin
               r_next.state = IDLE;
               r_next.flag = 1'b0;
            end
         endcase
      end
      // Pin selection: force wins over detection
      if (r_reg.control[BIT_FORCE]) begin
         r_next.pin = r_reg.control[BIT_FORCE_VALUE];
      end else begin
         r_next.pin = r_next.flag & r_reg.control[BIT_ENABLE];
      end
      // Write-one-to-clear; a same-cycle event wins over the clear
      if (hit_write && index == IDX_IRQ_STATUS) begin
         r_next.irq_status = r_reg.irq_status & ~bus_req.writedata[1:0];
      end
      r_next.irq_status = r_next.irq_status | events;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.state <= IDLE;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   assign bus_ans.readdata = r_reg.readdata;
   // Completion only on an enabled edge, so a frozen cycle cannot swallow a write
   assign bus_ans.waitrequest = (bus_req.read | bus_req.write) & ~(r_reg.answered & clk_en);
   assign over_range_flag_pin = r_reg.pin;
   assign irq = |(r_reg.irq_status & r_reg.irq_mask);

   property p_disabled_quiet;
      @(posedge clk) disable iff (reset)
         (clk_en && !r_reg.control[BIT_ENABLE] && !r_reg.control[BIT_FORCE])
            |=> !over_range_flag_pin;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("pin active while disabled");

   property p_follow;
      @(posedge clk) disable iff (reset)
         (clk_en && !r_reg.control[BIT_FORCE] && r_reg.control[BIT_ENABLE])
            |=> over_range_flag_pin == $past(r_next.flag);
   endproperty
   a_follow: assert property (p_follow) else $error("pin does not follow detection");

   property p_forced;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_FORCE])
            |=> over_range_flag_pin == $past(r_reg.control[BIT_FORCE_VALUE]);
   endproperty
   a_forced: assert property (p_forced) else $error("forced level wrong");

   property p_upper_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_UPPER_HIGH)
            |=> r_reg.upper[12:8] == $past(bus_req.writedata[4:0]);
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper high not stored");

   property p_lower_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_LOWER_LOW)
            |=> r_reg.lower[7:0] == $past(bus_req.writedata[7:0]);
   endproperty
   a_lower_write: assert property (p_lower_write) else $error("lower low not stored");

   property p_dwell_load;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && r_reg.state == ABOVE && below && !above)
            |=> r_reg.count == $past(r_reg.dwell);
   endproperty
   a_dwell_load: assert property (p_dwell_load) else $error("dwell not loaded");

   property p_dwell_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_DWELL_HIGH)
            |=> r_reg.dwell[15:8] == $past(bus_req.writedata[7:0]);
   endproperty
   a_dwell_write: assert property (p_dwell_write) else $error("dwell high not stored");

   property p_assert_on_above;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && r_reg.state == IDLE && above)
            |=> r_reg.flag ##0 r_reg.irq_status[BIT_EV_ASSERT];
   endproperty
   a_assert_on_above: assert property (p_assert_on_above) else $error("flag not raised");

   property p_count_step;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && r_reg.state == DWELL && below && !above
            && r_reg.count > 16'h0001)
            |=> r_reg.count == $past(r_reg.count) - 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("dwell count did not step");

   property p_answer_next;
      @(posedge clk) disable iff (reset)
         (clk_en && access)
            |=> r_reg.answered;
   endproperty
   a_answer_next: assert property (p_answer_next) else $error("request not answered");

   property p_answer_once;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.answered)
            |=> !r_reg.answered;
   endproperty
   a_answer_once: assert property (p_answer_once) else $error("answer held too long");

   property p_wait_pending;
      @(posedge clk) disable iff (reset)
         ((bus_req.read || bus_req.write) && !r_reg.answered)
            |-> bus_ans.waitrequest;
   endproperty
   a_wait_pending: assert property (p_wait_pending) else $error("waitrequest low too early");

   property p_high_reserved;
      @(posedge clk) disable iff (reset)
         (clk_en && access && bus_req.read && index == IDX_UPPER_HIGH)
            |=> bus_ans.readdata[31:5] == '0;
   endproperty
   a_high_reserved: assert property (p_high_reserved) else $error("reserved bits set");

   property p_upper_low_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_UPPER_LOW)
            |=> r_reg.upper[7:0] == $past(bus_req.writedata[7:0]);
   endproperty
   a_upper_low_write: assert property (p_upper_low_write) else $error("upper low not stored");

   property p_lower_high_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_LOWER_HIGH)
            |=> r_reg.lower[12:8] == $past(bus_req.writedata[4:0]);
   endproperty
   a_lower_high_write: assert property (p_lower_high_write) else $error("lower high lost");

   property p_dwell_low_write;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_DWELL_LOW)
            |=> r_reg.dwell[7:0] == $past(bus_req.writedata[7:0]);
   endproperty
   a_dwell_low_write: assert property (p_dwell_low_write) else $error("dwell low not stored");

   property p_idle_disabled;
      @(posedge clk) disable iff (reset)
         (clk_en && !r_reg.control[BIT_ENABLE])
            |=> r_reg.state == IDLE && !r_reg.flag;
   endproperty
   a_idle_disabled: assert property (p_idle_disabled) else $error("detection ran disabled");

   property p_hold_above;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && r_reg.state == ABOVE && !below)
            |=> r_reg.state == ABOVE && r_reg.flag;
   endproperty
   a_hold_above: assert property (p_hold_above) else $error("flag left before dwell");

   property p_rearm;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && r_reg.state == DWELL && (above || !below))
            |=> r_reg.state == ABOVE && r_reg.flag;
   endproperty
   a_rearm: assert property (p_rearm) else $error("dwell not restarted");

   property p_release_pin;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && !r_reg.control[BIT_FORCE]
            && r_reg.state == DWELL && below && !above && r_reg.count <= 16'h0001)
            |=> !over_range_flag_pin && r_reg.irq_status[BIT_EV_RELEASE];
   endproperty
   a_release_pin: assert property (p_release_pin) else $error("pin not released");

   property p_no_early_release;
      @(posedge clk) disable iff (reset)
         (clk_en && r_reg.control[BIT_ENABLE] && !r_reg.control[BIT_FORCE]
            && r_reg.state == DWELL && r_reg.count > 16'h0001)
            |=> over_range_flag_pin;
   endproperty
   a_no_early_release: assert property (p_no_early_release) else $error("early release");

   // Frozen cycles must not advance the dwell count or the bus handshake
   property p_freeze;
      @(posedge clk) disable iff (reset)
         !clk_en
            |=> $stable(r_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   property p_status_clear;
      @(posedge clk) disable iff (reset)
         (clk_en && hit_write && index == IDX_IRQ_STATUS
            && bus_req.writedata[BIT_EV_ASSERT] && !events[BIT_EV_ASSERT])
            |=> !r_reg.irq_status[BIT_EV_ASSERT];
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

   c_release: cover property (@(posedge clk) disable iff (reset)
      r_reg.state == DWELL ##1 r_reg.state == IDLE);
   c_forced_high: cover property (@(posedge clk) disable iff (reset)
      r_reg.control[BIT_FORCE] && over_range_flag_pin);
   c_irq: cover property (@(posedge clk) disable iff (reset) irq);
   c_rearm: cover property (@(posedge clk) disable iff (reset)
      r_reg.state == DWELL ##1 r_reg.state == ABOVE);
   c_frozen: cover property (@(posedge clk) disable iff (reset)
      !clk_en && over_range_flag_pin);
endmodule
`default_nettype wire

// *** testbench/agc_watcher.sv ***
`timescale 1ns/1ps
`default_nettype none
module agc_watcher (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic [7:0] rise_count
);
   logic last_reg;
   // Gain control reacts to new overload episodes only, so it counts rising edges
   always_ff @(posedge clk) begin
      if (reset) begin
         last_reg <= 1'b0;
         rise_count <= 8'h00;
      end else begin
         last_reg <= pin;
         if (pin && !last_reg) begin
            rise_count <= rise_count + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/adc_fast_threshold_detect_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_fast_threshold_detect_tb_top;
   import fast_detect_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [12:0] mag = 13'h0000;
   logic probe = 1'b0;
   bus_request_type req = '0;
   bus_answer_type ans;
   logic pin;
   logic irq;
   logic [7:0] rises;
   logic [7:0] base;
   logic [31:0] d;
   logic [31:0] rq[$];
   logic [1:0] pq[$];
   int err_count = 0;
   int samples_checked = 0;
   logic [9:0] idx_t[8] = '{IDX_DETECT_CONTROL, IDX_UPPER_LOW, IDX_UPPER_HIGH, IDX_LOWER_LOW,
      IDX_LOWER_HIGH, IDX_DWELL_LOW, IDX_DWELL_HIGH, 10'h300};
   logic [7:0] msk_t[8] = '{CONTROL_WRITE_MASK, 8'hFF, HIGH_WRITE_MASK, 8'hFF,
      HIGH_WRITE_MASK, 8'hFF, 8'hFF, 8'h00};
   adc_fast_threshold_detect u_adc_fast_threshold_detect (.clk(clk), .reset(reset),
      .clk_en(clk_en), .bus_req(req), .bus_ans(ans), .sample_magnitude(mag),
      .over_range_flag_pin(pin), .irq(irq));
   agc_watcher u_agc_watcher (.clk(clk), .reset(reset), .pin(pin), .rise_count(rises));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Request is held until waitrequest is seen low, then dropped for one cycle
   task automatic access(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: wd};
      @(posedge clk iff !ans.waitrequest);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      rq.push_back(exp);
      access(1'b0, idx, 32'h0);
   endtask
   task automatic watch(input int n, input logic [1:0] a, input logic [1:0] b);
      pq.push_back(a);
      if (n > 1) begin
         pq.push_back(b);
      end
      probe <= 1'b1;
      repeat (n) @(posedge clk);
      probe <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (req.read && !ans.waitrequest) begin
         check(ans.readdata, rq.pop_front());
      end
      if (probe) begin
         check({30'h0, irq, pin}, {30'h0, pq.pop_front()});
      end
   end
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h149A92D8));
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      foreach (idx_t[i]) rd(idx_t[i], 32'h0);
      foreach (idx_t[i]) begin
         d = $urandom;
         access(1'b1, idx_t[i], d);
         rd(idx_t[i], {24'h0, d[7:0] & msk_t[i]});
      end
      access(1'b1, IDX_DETECT_CONTROL, 32'h0);
      access(1'b1, IDX_UPPER_LOW, 32'h64);
      access(1'b1, IDX_UPPER_HIGH, 32'h0);
      access(1'b1, IDX_LOWER_LOW, 32'h32);
      access(1'b1, IDX_LOWER_HIGH, 32'h0);
      access(1'b1, IDX_DWELL_LOW, 32'h3);
      access(1'b1, IDX_DWELL_HIGH, 32'h0);
      mag <= 13'($urandom_range(101, 8191));
      base = rises;
      watch(1, 2'b00, 2'b00);
      access(1'b1, IDX_DETECT_CONTROL, 32'h0C);
      watch(1, 2'b01, 2'b00);
      access(1'b1, IDX_DETECT_CONTROL, 32'h08);
      watch(1, 2'b00, 2'b00);
      access(1'b1, IDX_DETECT_CONTROL, 32'h01);
      watch(1, 2'b01, 2'b00);
      mag <= 13'($urandom_range(0, 49));
      clk_en <= 1'b0;
      watch(2, 2'b01, 2'b01);
      clk_en <= 1'b1;
      @(posedge clk);
      mag <= 13'h0032;
      @(posedge clk);
      mag <= 13'($urandom_range(0, 49));
      repeat (3) @(posedge clk);
      watch(2, 2'b01, 2'b00);
      rd(IDX_IRQ_STATUS, 32'h3);
      access(1'b1, IDX_IRQ_MASK, 32'h1);
      watch(1, 2'b10, 2'b00);
      access(1'b1, IDX_IRQ_STATUS, 32'h1);
      watch(1, 2'b00, 2'b00);
      rd(IDX_IRQ_STATUS, 32'h2);
      check({24'h0, rises - base}, 32'h2);
      summarize();
   end
endmodule
`default_nettype wire
